// File: hdl/spr_register_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "spr_defines.svh"

// Summary of operation
// - Instruction and data bits are sampled on serial clock rising edges.
// - Read data bits are launched on serial clock falling edges.
// - Data pin is released to high impedance while chip select is high.
// - Output-enable pair set selects 4-wire; cleared shares the data pin.
// - LSB-first pair selects bit order; default is MSB first.
// - MSB first: direction flag, A14 down to A0, then D7 down to D0.
// - LSB first: A0 up to A14, direction flag, then D0 up to D7.
// - First data byte accesses the address carried by the instruction.
// - Each further byte while selected accesses an address stepped by one.
// - Step-up pair set increments the address, cleared decrements it.
// - Chip select high then low aborts and restarts at the instruction.
// - Configuration writes use only the first data nibble, any bit order.
// - Soft reset control sits at bits 0 and 7 of configuration.
// - Instruction occupies the first sixteen rising edges: address and flag.
// - Direction flag one means read, zero means write.
// - Written bytes land on their last bit; tuning waits for load request.
module spr_register_port
  import spr_pkg::*;
#(
  parameter int REG_DEPTH = 16
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_n,
  output logic             serial_out_pin,
  output logic             serial_out_pin_oe_n,
  // Device side
  output logic [15:0]      tuning_word
);
  spr_if bus ();

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_idle;
  logic        sdio_s;
  logic        lsb;
  logic [15:0] in_word;
  spr_byte_t   in_byte;
  spr_addr_t   stepped;

  spr_state_t  state;
  logic [3:0]  bit_cnt;
  logic [15:0] shift;
  spr_addr_t   addr;
  logic [3:0]  nib;
  spr_byte_t   tx;
  logic        load;
  logic        out_bit;
  logic        oe_sdio_n;
  logic        oe_sdo_n;
  logic        wr_en;
  logic        cfg_wr;
  spr_addr_t   wr_addr;
  spr_byte_t   wr_data;

  spr_state_t  next_state;
  logic [3:0]  next_bit_cnt;
  logic [15:0] next_shift;
  spr_addr_t   next_addr;
  logic [3:0]  next_nib;
  spr_byte_t   next_tx;
  logic        next_load;
  logic        next_out_bit;
  logic        next_oe_sdio_n;
  logic        next_oe_sdo_n;
  logic        next_wr_en;
  logic        next_cfg_wr;
  spr_addr_t   next_wr_addr;
  spr_byte_t   next_wr_data;

  // ==========================================================================
  // Pin synchronisers and register storage
  spr_pin_sync u_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdio_in   (sdio_in),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .cs_idle   (cs_idle),
    .sdio_s    (sdio_s)
  );

  spr_regfile #(
    .REG_DEPTH (REG_DEPTH)
  ) u_regs (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bus     (bus.regs)
  );

  // ==========================================================================
  // Bit assembly in either order
  assign lsb     = bus.lsb_first;
  assign in_word = lsb ? {sdio_s, shift[15:1]} : {shift[14:0], sdio_s};
  assign in_byte = lsb ? {sdio_s, shift[7:1]} : {shift[6:0], sdio_s};
  assign stepped = bus.step_up ? addr + 15'h0001 : addr - 15'h0001;

  // ==========================================================================
  // Transfer sequencer
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_addr      = addr;
    next_nib       = nib;
    next_tx        = tx;
    next_load      = 1'h0;
    next_out_bit   = out_bit;
    next_oe_sdio_n = oe_sdio_n;
    next_oe_sdo_n  = oe_sdo_n;
    next_wr_en     = 1'h0;
    next_cfg_wr    = 1'h0;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    // Fetch one cycle after the address settles, well ahead of the next fall
    if (load) begin
      next_tx = bus.rd_data;
    end
    if (cs_idle) begin
      next_state     = SPR_IDLE;
      next_bit_cnt   = 4'h0;
      next_oe_sdio_n = 1'h1;
      next_oe_sdo_n  = 1'h1;
    end else begin
      unique case (state)
        SPR_IDLE, SPR_INSTR: begin
          next_state = SPR_INSTR;
          if (sclk_rise) begin
            next_shift   = in_word;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `SPR_INSTR_LAST) begin
              next_bit_cnt = 4'h0;
              next_addr    = in_word[`SPR_ADDR_W-1:0];
              next_state   = in_word[`SPR_RW_BIT] ? SPR_READ : SPR_WRITE;
              next_load    = in_word[`SPR_RW_BIT];
            end
          end
        end
        SPR_WRITE: begin
          if (sclk_rise) begin
            next_shift   = {8'h00, in_byte};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt <= `SPR_NIBBLE_LAST) begin
              next_nib[bit_cnt[1:0]] = sdio_s;
            end
            if (bit_cnt == `SPR_BYTE_LAST) begin
              next_bit_cnt = 4'h0;
              next_wr_en   = 1'h1;
              next_cfg_wr  = (addr == `SPR_CFG_ADDR);
              next_wr_addr = addr;
              next_wr_data = in_byte;
              next_addr    = stepped;
            end
          end
        end
        SPR_READ: begin
          // Both pins carry the same bit; only the enables follow the wire mode
          if (sclk_fall) begin
            next_out_bit   = lsb ? tx[0] : tx[7];
            next_tx        = lsb ? {1'h0, tx[7:1]} : {tx[6:0], 1'h0};
            next_oe_sdio_n = bus.four_wire;
            next_oe_sdo_n  = ~bus.four_wire;
          end
          if (sclk_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `SPR_BYTE_LAST) begin
              next_bit_cnt = 4'h0;
              next_addr    = stepped;
              next_load    = 1'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state     <= SPR_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 16'h0000;
      addr      <= `SPR_CFG_ADDR;
      nib       <= 4'h0;
      tx        <= `SPR_REG_RESET;
      load      <= 1'h0;
      out_bit   <= 1'h0;
      oe_sdio_n <= 1'h1;
      oe_sdo_n  <= 1'h1;
      wr_en     <= 1'h0;
      cfg_wr    <= 1'h0;
      wr_addr   <= `SPR_CFG_ADDR;
      wr_data   <= `SPR_REG_RESET;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      addr      <= next_addr;
      nib       <= next_nib;
      tx        <= next_tx;
      load      <= next_load;
      out_bit   <= next_out_bit;
      oe_sdio_n <= next_oe_sdio_n;
      oe_sdo_n  <= next_oe_sdo_n;
      wr_en     <= next_wr_en;
      cfg_wr    <= next_cfg_wr;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
    end
  end

  // ==========================================================================
  // Outputs and register port
  assign sdio_out            = out_bit;
  assign sdio_oe_n           = oe_sdio_n;
  assign serial_out_pin      = out_bit;
  assign serial_out_pin_oe_n = oe_sdo_n;
  assign tuning_word         = bus.tuning_word;
  assign bus.wr_en           = wr_en;
  assign bus.cfg_wr          = cfg_wr;
  assign bus.wr_addr         = wr_addr;
  assign bus.wr_data         = wr_data;
  assign bus.cfg_nibble      = nib;
  assign bus.rd_addr         = addr;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Instruction and data steps shared by the checks below
  sequence instr_done_s;
    !cs_idle && (state == SPR_IDLE || state == SPR_INSTR) && sclk_rise &&
      bit_cnt == `SPR_INSTR_LAST;
  endsequence
  sequence write_byte_done_s;
    !cs_idle && state == SPR_WRITE && sclk_rise && bit_cnt == `SPR_BYTE_LAST;
  endsequence
  sequence read_byte_done_s;
    !cs_idle && state == SPR_READ && sclk_rise && bit_cnt == `SPR_BYTE_LAST;
  endsequence
  sequence nibble_bit_s;
    !cs_idle && state == SPR_WRITE && sclk_rise && bit_cnt <= `SPR_NIBBLE_LAST;
  endsequence
  sequence instr_bit_s;
    !cs_idle && (state == SPR_IDLE || state == SPR_INSTR) && sclk_rise;
  endsequence

  release_idle_a: assert property (cs_idle |=> (sdio_oe_n && serial_out_pin_oe_n))
    else $error("data pins driven while deselected");
  abort_restart_a: assert property (cs_idle |=> (state == SPR_IDLE && bit_cnt == 4'h0))
    else $error("deselect did not restart the transfer");
  launch_fall_a: assert property ($changed(out_bit) |-> $past(sclk_fall))
    else $error("read bit launched off a falling edge");
  sample_rise_a: assert property ($changed(shift) |-> $past(sclk_rise))
    else $error("input bit sampled off a rising edge");
  instr_len_a: assert property (instr_done_s |=>
    (state == SPR_READ) == $past(in_word[`SPR_RW_BIT]))
    else $error("instruction phase ended with wrong direction");
  first_addr_a: assert property (instr_done_s |=>
    addr == $past(in_word[`SPR_ADDR_W-1:0]))
    else $error("first data address not taken from instruction");
  write_commit_a: assert property (write_byte_done_s |=> (wr_en && wr_addr == $past(addr) &&
    wr_data == $past(in_byte)))
    else $error("written byte not committed on its last bit");
  addr_step_a: assert property (write_byte_done_s |=> addr == ($past(bus.step_up) ?
    $past(addr) + 15'h0001 : $past(addr) - 15'h0001))
    else $error("address not stepped after a byte");
  wire_mode_a: assert property ((!cs_idle && state == SPR_READ && sclk_fall) |=>
    (sdio_oe_n == $past(bus.four_wire) && serial_out_pin_oe_n != $past(bus.four_wire)))
    else $error("read data on the wrong pin for wire mode");
  cfg_only_a: assert property (cfg_wr |-> (wr_en && wr_addr == `SPR_CFG_ADDR))
    else $error("nibble check applied outside configuration register");
  read_step_a: assert property (read_byte_done_s |=> load &&
    addr == ($past(bus.step_up) ? $past(addr) + 15'h0001 : $past(addr) - 15'h0001))
    else $error("read address not stepped after a byte");
  nibble_take_a: assert property (nibble_bit_s |=>
    nib[$past(bit_cnt[1:0])] == $past(sdio_s))
    else $error("configuration nibble bit not captured in arrival order");
  bit_order_a: assert property (instr_bit_s |=>
    ($past(lsb) ? shift[`SPR_RW_BIT] : shift[0]) == $past(sdio_s))
    else $error("instruction bit entered at the wrong end");
  abort_drop_a: assert property (cs_idle |=> !wr_en)
    else $error("write committed after deselect");
  cfg_apply_a: assert property (cfg_wr |=> bus.lsb_first == $past(nib[1]) &&
    bus.step_up == $past(nib[2]) && bus.four_wire == $past(nib[3]))
    else $error("configuration nibble not applied");
  load_fetch_a: assert property (load |=> tx == $past(bus.rd_data))
    else $error("read byte not fetched from the register file");
endmodule

`default_nettype wire

// File: hdl/spr_defines.svh
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH

// ==========================================================================
// Serial format
`define SPR_ADDR_W       15
`define SPR_DATA_W       8
`define SPR_INSTR_LAST   4'hF
`define SPR_BYTE_LAST    4'h7
`define SPR_NIBBLE_LAST  4'h3
`define SPR_RW_BIT       15
`define SPR_SCLK_MAX_MHZ 100

// ==========================================================================
// Register map
`define SPR_CFG_ADDR     15'h0000
`define SPR_TUNE_LO_ADDR 15'h000A
`define SPR_TUNE_HI_ADDR 15'h000B
`define SPR_LOAD_ADDR    15'h000C
`define SPR_LOAD_BIT     0
`define SPR_REG_RESET    8'h00
`define SPR_TUNE_RESET   16'h0000

// ==========================================================================
// Interface configuration fields, upper and mirrored lower copy
`define SPR_CFG_SRST_HI  7
`define SPR_CFG_LSB_HI   6
`define SPR_CFG_INC_HI   5
`define SPR_CFG_SDO_HI   4
`define SPR_CFG_SDO_LO   3
`define SPR_CFG_INC_LO   2
`define SPR_CFG_LSB_LO   1
`define SPR_CFG_SRST_LO  0

`endif

// File: hdl/spr_pkg.sv
package spr_pkg;

  typedef enum logic [1:0] {
    SPR_IDLE  = 2'h0,
    SPR_INSTR = 2'h1,
    SPR_READ  = 2'h3,
    SPR_WRITE = 2'h2
  } spr_state_t;

  typedef logic [14:0] spr_addr_t;
  typedef logic [7:0]  spr_byte_t;

endpackage

// File: hdl/spr_if.sv
`timescale 1ns/100ps
`default_nettype none

interface spr_if;
  import spr_pkg::*;
  logic        wr_en;
  logic        cfg_wr;
  spr_addr_t   wr_addr;
  spr_byte_t   wr_data;
  logic [3:0]  cfg_nibble;
  spr_addr_t   rd_addr;
  spr_byte_t   rd_data;
  logic        lsb_first;
  logic        step_up;
  logic        four_wire;
  logic [15:0] tuning_word;

  modport core (
    output wr_en, cfg_wr, wr_addr, wr_data, cfg_nibble, rd_addr,
    input  rd_data, lsb_first, step_up, four_wire, tuning_word
  );
  modport regs (
    input  wr_en, cfg_wr, wr_addr, wr_data, cfg_nibble, rd_addr,
    output rd_data, lsb_first, step_up, four_wire, tuning_word
  );
endinterface

`default_nettype wire

// File: hdl/spr_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module spr_pin_sync (
  // System
  input  wire logic clk_sys,
  input  wire logic reset,
  // Raw pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdio_in,
  // Synchronised view
  output logic      sclk_rise,
  output logic      sclk_fall,
  output logic      cs_idle,
  output logic      sdio_s
);
  // Bit order in the stages: {sdio, cs_n, sclk}
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic       sclk_prev;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;
  logic       next_sclk_prev;

  always_comb begin
    next_stage1    = {sdio_in, cs_n, sclk};
    next_stage2    = stage1;
    next_sclk_prev = stage2[0];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1    <= 3'h2;
      stage2    <= 3'h2;
      sclk_prev <= 1'h0;
    end else begin
      stage1    <= next_stage1;
      stage2    <= next_stage2;
      sclk_prev <= next_sclk_prev;
    end
  end

  assign sclk_rise = stage2[0] & ~sclk_prev;
  assign sclk_fall = ~stage2[0] & sclk_prev;
  assign cs_idle   = stage2[1];
  assign sdio_s    = stage2[2];
endmodule

`default_nettype wire

// File: hdl/spr_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "spr_defines.svh"

module spr_regfile
  import spr_pkg::*;
#(
  parameter int REG_DEPTH = 16
) (
  // System
  input  wire logic clk_sys,
  input  wire logic reset,
  // Core side
  spr_if.regs       bus
);
  localparam int IDX_W = $clog2(REG_DEPTH);
  localparam logic [IDX_W-1:0] CFG_IDX = IDX_W'(`SPR_CFG_ADDR);
  localparam logic [IDX_W-1:0] TLO_IDX = IDX_W'(`SPR_TUNE_LO_ADDR);
  localparam logic [IDX_W-1:0] THI_IDX = IDX_W'(`SPR_TUNE_HI_ADDR);

  spr_byte_t   regs [REG_DEPTH];
  spr_byte_t   next_regs [REG_DEPTH];
  logic [15:0] tuning;
  logic [15:0] next_tuning;
  logic [3:0]  nib;
  logic        wr_hit;
  logic        rd_hit;

  // ==========================================================================
  // Next values
  always_comb begin
    nib         = bus.cfg_nibble;
    next_regs   = regs;
    next_tuning = tuning;
    wr_hit      = bus.wr_en && (bus.wr_addr < spr_addr_t'(REG_DEPTH));
    if (regs[CFG_IDX][`SPR_CFG_SRST_HI]) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        next_regs[i] = `SPR_REG_RESET;
      end
      next_tuning = `SPR_TUNE_RESET;
    end else if (wr_hit && bus.cfg_wr) begin
      next_regs[CFG_IDX] = {nib[0], nib[1], nib[2], nib[3],
                            nib[3], nib[2], nib[1], nib[0]};
    end else if (wr_hit && bus.wr_addr == `SPR_LOAD_ADDR) begin
      if (bus.wr_data[`SPR_LOAD_BIT]) begin
        next_tuning = {regs[THI_IDX], regs[TLO_IDX]};
      end
    end else if (wr_hit) begin
      next_regs[bus.wr_addr[IDX_W-1:0]] = bus.wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs[i] <= `SPR_REG_RESET;
      end
      tuning <= `SPR_TUNE_RESET;
    end else begin
      regs   <= next_regs;
      tuning <= next_tuning;
    end
  end

  // ==========================================================================
  // Read side and configuration view
  assign rd_hit          = (bus.rd_addr < spr_addr_t'(REG_DEPTH)) &&
                           (bus.rd_addr != `SPR_LOAD_ADDR);
  assign bus.rd_data     = rd_hit ? regs[bus.rd_addr[IDX_W-1:0]] : `SPR_REG_RESET;
  assign bus.lsb_first   = regs[CFG_IDX][`SPR_CFG_LSB_HI];
  assign bus.step_up     = regs[CFG_IDX][`SPR_CFG_INC_HI];
  assign bus.four_wire   = regs[CFG_IDX][`SPR_CFG_SDO_HI];
  assign bus.tuning_word = tuning;

  // ==========================================================================
  // Checks
  cfg_mirror_a: assert property (@(posedge clk_sys) disable iff (reset)
    {regs[CFG_IDX][`SPR_CFG_SRST_HI], regs[CFG_IDX][`SPR_CFG_LSB_HI],
     regs[CFG_IDX][`SPR_CFG_INC_HI], regs[CFG_IDX][`SPR_CFG_SDO_HI]} ==
    {regs[CFG_IDX][`SPR_CFG_SRST_LO], regs[CFG_IDX][`SPR_CFG_LSB_LO],
     regs[CFG_IDX][`SPR_CFG_INC_LO], regs[CFG_IDX][`SPR_CFG_SDO_LO]})
    else $error("configuration halves not mirrored");
  soft_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    regs[CFG_IDX][`SPR_CFG_SRST_HI] |=>
      (regs[CFG_IDX] == `SPR_REG_RESET && tuning == `SPR_TUNE_RESET))
    else $error("soft reset did not clear registers");
  tuning_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(tuning) |-> ($past(regs[CFG_IDX][`SPR_CFG_SRST_HI]) ||
      ($past(bus.wr_en) && $past(bus.wr_addr) == `SPR_LOAD_ADDR)))
    else $error("tuning word changed without load request");
endmodule

`default_nettype wire

// File: verif/spr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module spr_host_model
  import spr_pkg::*;
(
  // System
  input  wire logic clk_sys,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_pin_oe_n
);
  logic host_drv;
  logic host_bit;
  logic last_bit = 1'b0;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_drv = 1'b0;
    host_bit = 1'b0;
  end

  // ==========================================================================
  // Shared data line: host, device, or a released line showing its last value inverted
  always_comb begin
    if (host_drv) sdio_in = host_bit;
    else if (!sdio_oe_n) sdio_in = sdio_out;
    else sdio_in = ~last_bit;
  end

  always @(posedge clk_sys) begin
    if (host_drv || !sdio_oe_n) last_bit <= sdio_in;
  end

  // ==========================================================================
  // Serial clock held low between frames, 160 ns period within them
  task automatic half();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  task automatic clock_bit(input logic drv, input logic b, output logic r);
    host_drv = drv;
    host_bit = b;
    half();
    sclk = 1'b1;
    r = !serial_out_pin_oe_n ? serial_out_pin : sdio_in;
    half();
    sclk = 1'b0;
  endtask

  // One framed transfer of nb data bits; a count short of a byte aborts
  task automatic xfer(input logic rw, input logic lsb, input spr_addr_t a,
                      input int nb, input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    int   p;
    rd = '0;
    cs_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 16; i++) begin
      clock_bit(1'b1, lsb ? (i < 15 ? a[i] : rw) : (i == 0 ? rw : a[15 - i]), r);
    end
    for (int j = 0; j < nb; j++) begin
      p = 8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8);
      clock_bit(!rw, wd[p], r);
      rd[p] = r;
    end
    host_drv = 1'b0;
    half();
    cs_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
endmodule

`default_nettype wire

// File: verif/tb_spr_register_port.sv
`timescale 1ns/100ps
`default_nettype none

module tb_spr_register_port;
  import spr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        sdio_in;
  logic        sdio_out;
  logic        sdio_oe_n;
  logic        serial_out_pin;
  logic        serial_out_pin_oe_n;
  logic [15:0] tuning_word;
  logic        lsb_mode = 1'b0;
  logic        sdio_seen = 1'b0;
  logic        sop_seen = 1'b0;
  logic        seen_clr = 1'b0;
  int          n_errors = 0;
  int          tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  spr_register_port #(.REG_DEPTH(16)) i_spr_register_port (
    .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe_n(serial_out_pin_oe_n), .tuning_word(tuning_word)
  );

  spr_host_model i_spr_host_model (
    .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe_n(serial_out_pin_oe_n)
  );

  // Which output pin the device ever enabled since last cleared
  always @(posedge clk_sys) begin
    if (seen_clr) begin
      sdio_seen <= 1'b0;
      sop_seen <= 1'b0;
    end else begin
      if (!sdio_oe_n) sdio_seen <= 1'b1;
      if (!serial_out_pin_oe_n) sop_seen <= 1'b1;
    end
  end

  // ==========================================================================
  // Access tasks and comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input spr_addr_t a, input int n, input logic [31:0] d);
    logic [31:0] x;
    i_spr_host_model.xfer(1'b0, lsb_mode, a, n * 8, d, x);
  endtask

  task automatic rchk(input spr_addr_t a, input int n, input logic [31:0] exp);
    logic [31:0] v;
    i_spr_host_model.xfer(1'b1, lsb_mode, a, n * 8, 32'h0, v);
    check(v, exp);
  endtask

  task automatic clr_seen();
    seen_clr = 1'b1;
    @(posedge clk_sys);
    #1;
    seen_clr = 1'b0;
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    logic [31:0] x;
    repeat (12) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(sdio_oe_n, 1'b1);
    check(serial_out_pin_oe_n, 1'b1);
    check(tuning_word, 16'h0000);
    rchk(15'h0000, 1, 32'h00);
    wr(15'h0001, 1, 32'hA5);
    clr_seen();
    rchk(15'h0001, 1, 32'hA5);
    check(sdio_seen, 1'b1);
    check(sop_seen, 1'b0);
    check(sdio_oe_n, 1'b1);
    // Default step direction is down
    wr(15'h0005, 3, 32'h00332211);
    rchk(15'h0003, 1, 32'h33);
    rchk(15'h0005, 3, 32'h00332211);
    // Abort after one byte and four more bits
    i_spr_host_model.xfer(1'b0, 1'b0, 15'h0002, 12, 32'h00000F44, x);
    rchk(15'h0002, 1, 32'h44);
    rchk(15'h0001, 1, 32'hA5);
    // Configuration: only the first nibble counts, pairs mirrored
    wr(15'h0000, 1, 32'h2B);
    rchk(15'h0000, 1, 32'h24);
    wr(15'h0006, 3, 32'h00998877);
    rchk(15'h0008, 1, 32'h99);
    rchk(15'h0006, 3, 32'h00998877);
    // 4-wire form
    wr(15'h0000, 1, 32'h3A);
    clr_seen();
    rchk(15'h0007, 2, 32'h9988);
    check(sdio_seen, 1'b0);
    check(sop_seen, 1'b1);
    rchk(15'h0000, 1, 32'h3C);
    // LSB-first ordering
    wr(15'h0000, 1, 32'h40);
    lsb_mode = 1'b1;
    rchk(15'h0000, 1, 32'h42);
    wr(15'h0009, 1, 32'hC3);
    rchk(15'h0009, 1, 32'hC3);
    wr(15'h0000, 1, 32'h04);
    lsb_mode = 1'b0;
    rchk(15'h0000, 1, 32'h24);
    // Tuning word waits for its load request
    wr(15'h000A, 2, 32'h00001234);
    check(tuning_word, 16'h0000);
    wr(15'h000C, 1, 32'h01);
    check(tuning_word, 16'h1234);
    rchk(15'h000C, 1, 32'h00);
    // Address outside the register file
    wr(15'h0020, 1, 32'h55);
    rchk(15'h0020, 1, 32'h00);
    // Soft reset clears everything
    wr(15'h0000, 1, 32'h84);
    check(tuning_word, 16'h0000);
    rchk(15'h0000, 1, 32'h00);
    rchk(15'h0001, 1, 32'h00);
    results();
  end

  // ==========================================================================
  // Watchdog
  initial begin
    #600000;
    n_errors++;
    results();
  end
endmodule

`default_nettype wire
